// [bench/irp_host_model.sv]
// host side: counts paced pulses per core
// assumes pulses synchronous to clk_i
`timescale 1ns/1ps
module irp_host_model (
  input  wire       clk_i,
  input  wire       rst_i,
  input  wire [2:0] rx_irq_i,
  input  wire [2:0] tx_irq_i,
  output int        rx_cnt_o [3],
  output int        tx_cnt_o [3]
);
  always @(posedge clk_i or posedge rst_i) begin
    for (int i = 0; i < 3; i++) begin
      if (rst_i) begin
        rx_cnt_o[i] <= 0;
        tx_cnt_o[i] <= 0;
      end else begin
        rx_cnt_o[i] <= rx_cnt_o[i] + rx_irq_i[i];
        tx_cnt_o[i] <= tx_cnt_o[i] + tx_irq_i[i];
      end
    end
  end
endmodule

// [bench/irp_top_chk.sv]
// checker: bus wait states and paced pulse relations
// assumes binding to irp_top ports
`timescale 1ns/1ps
module irp_chk (
  input wire        CLK_I,
  input wire        SYS_RST_I,
  input wire        AVS_READ_I,
  input wire        AVS_WRITE_I,
  input wire [31:0] AVS_READDATA_O,
  input wire        AVS_WAITREQUEST_O,
  input wire [2:0]  RX_EVENT_I,
  input wire [2:0]  TX_EVENT_I,
  input wire [2:0]  CORE_RX_PACED_IRQ_O,
  input wire [2:0]  CORE_TX_PACED_IRQ_O
);
  logic [2:0] rx_seen_q;
  logic [2:0] tx_seen_q;
  wire        req = AVS_READ_I | AVS_WRITE_I;
  default clocking @(posedge CLK_I); endclocking
  default disable iff (SYS_RST_I);
  ////////////////////////////////////////
  always @(posedge CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      rx_seen_q <= 3'h0;
      tx_seen_q <= 3'h0;
    end else begin
      rx_seen_q <= rx_seen_q | RX_EVENT_I;
      tx_seen_q <= tx_seen_q | TX_EVENT_I;
    end
  end
  ////////////////////////////////////////
  a_wait_once: assert property (req && AVS_WAITREQUEST_O |=> !AVS_WAITREQUEST_O)
    else $error("more than one wait state");
  a_wait_first: assert property ($rose(req) |-> AVS_WAITREQUEST_O)
    else $error("new request not held");
  a_idle_nowait: assert property (!req |-> !AVS_WAITREQUEST_O)
    else $error("waitrequest while idle");
  a_rdata_hold: assert property (!(AVS_READ_I && AVS_WAITREQUEST_O) |=> $stable(AVS_READDATA_O))
    else $error("read data changed without read");
  a_rx_one_pulse: assert property ((CORE_RX_PACED_IRQ_O & $past(CORE_RX_PACED_IRQ_O & ~RX_EVENT_I)) == 3'h0)
    else $error("rx pulse repeated without event");
  a_tx_one_pulse: assert property ((CORE_TX_PACED_IRQ_O & $past(CORE_TX_PACED_IRQ_O & ~TX_EVENT_I)) == 3'h0)
    else $error("tx pulse repeated without event");
  a_rx_pulse_cause: assert property ((CORE_RX_PACED_IRQ_O & ~rx_seen_q) == 3'h0)
    else $error("rx pulse without event");
  a_tx_pulse_cause: assert property ((CORE_TX_PACED_IRQ_O & ~tx_seen_q) == 3'h0)
    else $error("tx pulse without event");
endmodule
bind irp_top irp_chk u_chk (.CLK_I, .SYS_RST_I, .AVS_READ_I, .AVS_WRITE_I, .AVS_READDATA_O,
  .AVS_WAITREQUEST_O, .RX_EVENT_I, .TX_EVENT_I, .CORE_RX_PACED_IRQ_O, .CORE_TX_PACED_IRQ_O);

// [bench/irp_top_tb.sv]
// bench: registers, pace counter model and pulse blocking
// assumes checker bound from irp_top_chk.sv
`timescale 1ns/1ps
module irp_top_tb;
  logic        CLK_I = 1'b0;
  logic        SYS_RST_I = 1'b1;
  logic [7:0]  AVS_ADDRESS_I = 8'h00;
  logic        AVS_READ_I = 1'b0;
  logic        AVS_WRITE_I = 1'b0;
  logic [31:0] AVS_WRITEDATA_I = 32'h0;
  logic [2:0]  RX_EVENT_I = 3'h0;
  logic [2:0]  TX_EVENT_I = 3'h0;
  wire  [31:0] AVS_READDATA_O;
  wire         AVS_WAITREQUEST_O;
  wire  [2:0]  CORE_RX_PACED_IRQ_O;
  wire  [2:0]  CORE_TX_PACED_IRQ_O;
  int          rx_cnt [3];
  int          tx_cnt [3];
  int          fail_count = 0;
  int          num_checks = 0;
  integer      seed = 20;
  logic [31:0] d;
  int          pace, c0, c1, k;
  int          cnts [7] = '{9, 1, 3, 5, 7, 5, 0};
  logic [7:0]  ra [10] = '{8'h10, 8'h14, 8'h18, 8'h20, 8'h24, 8'h28, 8'h30, 8'h34, 8'h38, 8'h40};
  always #5 CLK_I = ~CLK_I;
  irp_top #(.TICK_DIV(1)) uut (.CLK_I(CLK_I), .SYS_RST_I(SYS_RST_I), .AVS_ADDRESS_I(AVS_ADDRESS_I),
    .AVS_READ_I(AVS_READ_I), .AVS_WRITE_I(AVS_WRITE_I), .AVS_WRITEDATA_I(AVS_WRITEDATA_I),
    .AVS_BYTEENABLE_I(4'hf), .AVS_READDATA_O(AVS_READDATA_O), .AVS_WAITREQUEST_O(AVS_WAITREQUEST_O),
    .RX_EVENT_I(RX_EVENT_I), .TX_EVENT_I(TX_EVENT_I), .CORE_RX_PACED_IRQ_O(CORE_RX_PACED_IRQ_O),
    .CORE_TX_PACED_IRQ_O(CORE_TX_PACED_IRQ_O));
  irp_host_model host (.clk_i(CLK_I), .rst_i(SYS_RST_I), .rx_irq_i(CORE_RX_PACED_IRQ_O),
    .tx_irq_i(CORE_TX_PACED_IRQ_O), .rx_cnt_o(rx_cnt), .tx_cnt_o(tx_cnt));
  ////////////////////////////////////////
  function automatic int nxt(input int p, input int c, input int t);
    if (2 * c > 4 * t) return 255;
    if (2 * c > 3 * t) return (2 * p + 1 > 255) ? 255 : 2 * p + 1;
    if (2 * c > 2 * t) return (p == 255) ? 255 : p + 1;
    if (2 * c > t) return (p == 0) ? 0 : p - 1;
    if (c != 0) return p / 2;
    return 0;
  endfunction
  task automatic close_out();
    $display("checks %0d errors %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] %0t seen %h exp %h", $time, seen, exp);
    end
  endtask
  task automatic bus(input bit wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
    int n;
    n = 0;
    AVS_ADDRESS_I <= a;
    AVS_WRITEDATA_I <= wd;
    AVS_WRITE_I <= wr;
    AVS_READ_I <= !wr;
    do begin
      @(posedge CLK_I);
      n++;
    end while (AVS_WAITREQUEST_O !== 1'b0 && n < 50);
    if (n >= 50) begin
      check(1, 0);
      close_out();
    end
    rd = AVS_READDATA_O;
    AVS_READ_I <= 1'b0;
    AVS_WRITE_I <= 1'b0;
    @(posedge CLK_I);
  endtask
  task automatic ev(input bit tx, input logic [2:0] m);
    if (tx) TX_EVENT_I <= m;
    else RX_EVENT_I <= m;
    @(posedge CLK_I);
    TX_EVENT_I <= 3'h0;
    RX_EVENT_I <= 3'h0;
    @(posedge CLK_I);
  endtask
  task automatic wait_idx(input int lo, input int hi);
    int n;
    n = 0;
    do begin
      bus(0, 8'h3c, 0, d);
      n++;
    end while (!(d >= lo && d <= hi) && n < 300);
    if (n >= 300) begin
      check(1, 0);
      close_out();
    end
  endtask
  ////////////////////////////////////////
  initial begin
    repeat (5) @(posedge CLK_I);
    SYS_RST_I <= 1'b0;
    @(posedge CLK_I);
    bus(0, 8'h00, 0, d);
    check(d, 32'h0190_0000);
    bus(1, 8'h00, 32'h0001_0001, d);
    for (k = 0; k < 10; k++) begin
      bus(0, ra[k], 0, d);
      check(d, 0);
    end
    for (k = 0; k < 6; k++) begin
      d = $random(seed);
      bus(1, ra[k], {d[31:6], 6'(k + 4)}, d);
    end
    bus(1, 8'h40, $random(seed), d);
    for (k = 0; k < 7; k++) begin
      bus(0, ra[k < 6 ? k : 9], 0, d);
      check(d, k < 6 ? k + 4 : 0);
    end
    bus(0, 8'h00, 0, d);
    check(d, 32'h0001_0001);
    c0 = tx_cnt[0];
    ev(1, 3'h1);
    repeat (2) @(posedge CLK_I);
    check(tx_cnt[0] - c0, 1);
    pace = 0;
    for (int w = 0; w < 7; w++) begin
      wait_idx(20, 60);
      c0 = rx_cnt[0];
      c1 = rx_cnt[1];
      repeat (cnts[w]) ev(0, 3'h3);
      repeat (2) @(posedge CLK_I);
      check(rx_cnt[1] - c1, cnts[w]);
      if (pace == 0) check(rx_cnt[0] - c0, cnts[w]);
      if (pace >= 100 && pace < 250) begin
        check(rx_cnt[0] - c0, 0);
        wait_idx(pace + 5, 249);
        check(rx_cnt[0] - c0, 1);
      end
      wait_idx(0, 15);
      pace = nxt(pace, cnts[w], 4);
      bus(0, 8'h30, 0, d);
      check(d, 32'(pace));
    end
    check(rx_cnt[2] + tx_cnt[1] + tx_cnt[2], 0);
    close_out();
  end
endmodule

// [hw/irp_pacer.v]
// one pacer: counts events over a window, adapts pace counter, blocks and holds pulses
// assumes a shared window index and window end pulse from the parent
`timescale 1ns/1ps
`include "irp_regs.vh"

module irp_pacer (
  input  wire                     clk_i,
  input  wire                     rst_i,
  input  wire                     win_end_i,
  input  wire [`IRP_IDX_W-1:0]    idx_i,
  input  wire [`IRP_PRE_W-1:0]    prescale_i,
  input  wire [`IRP_TGT_W-1:0]    target_i,
  input  wire                     enable_i,
  input  wire                     event_i,
  output reg                      pulse_o,
  output wire [`IRP_PACE_W-1:0]   pace_o
);

  reg  [`IRP_CNT_W-1:0]  count_q;
  reg  [`IRP_PACE_W-1:0] pace_q;
  reg  [`IRP_PACE_W-1:0] pace_d;
  reg                    pend_q;
  wire [`IRP_CNT_W:0]    cnt2;
  wire [`IRP_CNT_W:0]    t1;
  wire [`IRP_CNT_W:0]    t2;
  wire [`IRP_CNT_W:0]    t3;
  wire [`IRP_CNT_W:0]    t4;
  wire [`IRP_IDX_W-1:0]  block_len;
  wire                   blocked;
  wire                   fire;
  wire [`IRP_PACE_W:0]   dbl;

  assign pace_o = pace_q;

  ////////////////////////////////////////////////////////////
  // thresholds compared as twice the count
  assign cnt2 = {count_q, 1'b0};
  assign t1   = {{(`IRP_CNT_W+1-`IRP_TGT_W){1'b0}}, target_i};
  assign t2   = {t1[`IRP_CNT_W-1:0], 1'b0};
  assign t3   = t2 + t1;
  assign t4   = {t2[`IRP_CNT_W-1:0], 1'b0};
  assign dbl  = {pace_q, 1'b1};

  always @* begin
    if (cnt2 > t4) begin
      pace_d = `IRP_PACE_MAX;
    end else if (cnt2 > t3) begin
      pace_d = dbl[`IRP_PACE_W] ? `IRP_PACE_MAX : dbl[`IRP_PACE_W-1:0];
    end else if (cnt2 > t2) begin
      pace_d = (pace_q == `IRP_PACE_MAX) ? pace_q : pace_q + 8'h01;
    end else if (cnt2 > t1) begin
      pace_d = (pace_q == 8'h00) ? pace_q : pace_q - 8'h01;
    end else if (count_q != 16'h0000) begin
      pace_d = {1'b0, pace_q[`IRP_PACE_W-1:1]};
    end else begin
      pace_d = 8'h00;
    end
  end

  ////////////////////////////////////////////////////////////
  // event count and pace counter
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      count_q <= 16'h0000;
      pace_q  <= 8'h00;
    end else if (win_end_i) begin
      count_q <= {15'h0000, event_i};
      pace_q  <= pace_d;
    end else if (event_i && count_q != 16'hffff) begin
      count_q <= count_q + 16'h0001;
    end
  end

  ////////////////////////////////////////////////////////////
  // blocking and pending pulse
  assign block_len = {{(`IRP_IDX_W-`IRP_PRE_W){1'b0}}, prescale_i} * {{(`IRP_IDX_W-`IRP_PACE_W){1'b0}}, pace_q};
  assign blocked   = enable_i && (idx_i < block_len);
  assign fire      = (pend_q || event_i) && !blocked;

  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      pend_q  <= 1'b0;
      pulse_o <= 1'b0;
    end else begin
      pulse_o <= fire;
      pend_q  <= (pend_q || event_i) && blocked;
    end
  end

endmodule

// [hw/irp_regs.vh]
// register map, field positions, reset values and timing counts of the interrupt rate pacer
// assumes inclusion by the pacer design files only
`ifndef IRP_REGS_VH
`define IRP_REGS_VH

// avalon byte offsets
`define IRP_CTRL_OFS        8'h00
`define IRP_RX_TGT0_OFS     8'h10
`define IRP_RX_TGT1_OFS     8'h14
`define IRP_RX_TGT2_OFS     8'h18
`define IRP_TX_TGT0_OFS     8'h20
`define IRP_TX_TGT1_OFS     8'h24
`define IRP_TX_TGT2_OFS     8'h28
`define IRP_PACE0_OFS       8'h30
`define IRP_PACE1_OFS       8'h34
`define IRP_PACE2_OFS       8'h38
`define IRP_WIN_OFS         8'h3c

// interrupt_control_reg fields
`define IRP_CTRL_RXEN_LSB   0
`define IRP_CTRL_TXEN_LSB   8
`define IRP_CTRL_PRE_LSB    16
`define IRP_PRE_W           12

// target fields
`define IRP_TGT_W           6
`define IRP_TGT_RST         6'h00

// reset values
`define IRP_EN_RST          3'h0
`define IRP_PRE_RST         12'h190

// timing
`define IRP_TICKS_PER_PRE   250
`define IRP_PACE_W          8
`define IRP_PACE_MAX        8'hff
`define IRP_CNT_W           16
`define IRP_IDX_W           20

`endif

// [hw/irp_top.v]
// interrupt rate pacer: three cores, rx and tx pacing, avalon-mm register slave
// assumes events are one-cycle pulses synchronous to CLK_I
//
// Behaviour
// - each of three cores has independent rx and tx target registers and pacers
// - rx target is six low bits; upper bits read zero
// - tx target six low bits; software writes only two to sixty-three
// - limiting applies only while the matching pacing enable bit is set
// - window is prescale*250 ticks; first prescale*pace ticks block pulses
// - new events counted per window; count restarts at every window start
// - count above 2x target gives 255; above 1.5x doubles plus one
// - count above target but not 1.5x increments pace counter
// - above half target decrements; nonzero below halves; zero clears
//
// The implementer's own choices: the Avalon-MM slave port and the address map.
`timescale 1ns/1ps
`include "irp_regs.vh"

module irp_top #(
  parameter TICK_DIV = 1
) (
  input  wire        CLK_I,
  input  wire        SYS_RST_I,
  input  wire [7:0]  AVS_ADDRESS_I,
  input  wire        AVS_READ_I,
  input  wire        AVS_WRITE_I,
  input  wire [31:0] AVS_WRITEDATA_I,
  input  wire [3:0]  AVS_BYTEENABLE_I,
  output reg  [31:0] AVS_READDATA_O,
  output wire        AVS_WAITREQUEST_O,
  input  wire [2:0]  RX_EVENT_I,
  input  wire [2:0]  TX_EVENT_I,
  output wire [2:0]  CORE_RX_PACED_IRQ_O,
  output wire [2:0]  CORE_TX_PACED_IRQ_O
);

  reg  [2:0]              rx_en_q;
  reg  [2:0]              tx_en_q;
  reg  [`IRP_PRE_W-1:0]   tick_prescale_q;
  reg  [`IRP_TGT_W-1:0]   rx_target_rate_q [0:2];
  reg  [`IRP_TGT_W-1:0]   tx_target_rate_q [0:2];
  reg                     ack_q;
  reg  [15:0]             div_q;
  reg                     tick_q;
  reg  [`IRP_IDX_W-1:0]   idx_q;
  wire [`IRP_PRE_W-1:0]   pre_eff;
  wire [`IRP_IDX_W-1:0]   win_len;
  wire [31:0]             win_prod;
  wire                    win_end;
  wire                    take;
  wire                    wr_take;
  wire                    rd_take;
  wire [`IRP_PACE_W-1:0]  rx_pace [0:2];
  wire [`IRP_PACE_W-1:0]  tx_pace [0:2];
  reg  [31:0]             rd_mux;
  integer                 k;

  ////////////////////////////////////////////////////////////
  // byte-lane merge for register writes
  function [31:0] be_merge;
    input [31:0] old_v;
    input [31:0] new_v;
    input [3:0]  be;
    integer      b;
    begin
      be_merge = old_v;
      for (b = 0; b < 4; b = b + 1) begin
        if (be[b]) begin
          be_merge[b*8 +: 8] = new_v[b*8 +: 8];
        end
      end
    end
  endfunction

  ////////////////////////////////////////////////////////////
  // avalon slave: one wait state per access
  assign take              = (AVS_READ_I || AVS_WRITE_I) && !ack_q;
  assign wr_take           = AVS_WRITE_I && !ack_q;
  assign rd_take           = AVS_READ_I && !ack_q;
  assign AVS_WAITREQUEST_O = (AVS_READ_I || AVS_WRITE_I) && !ack_q;

  always @(posedge CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= take;
    end
  end

  ////////////////////////////////////////////////////////////
  // writable registers
  always @(posedge CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      rx_en_q         <= `IRP_EN_RST;
      tx_en_q         <= `IRP_EN_RST;
      tick_prescale_q <= `IRP_PRE_RST;
      for (k = 0; k < 3; k = k + 1) begin
        rx_target_rate_q[k] <= `IRP_TGT_RST;
        tx_target_rate_q[k] <= `IRP_TGT_RST;
      end
    end else if (wr_take) begin
      case (AVS_ADDRESS_I)
        `IRP_CTRL_OFS: begin
          {tick_prescale_q, tx_en_q, rx_en_q} <= control_next(be_merge(ctrl_rd(rx_en_q, tx_en_q, tick_prescale_q),
                                                                      AVS_WRITEDATA_I, AVS_BYTEENABLE_I));
        end
        `IRP_RX_TGT0_OFS: begin
          if (AVS_BYTEENABLE_I[0]) rx_target_rate_q[0] <= AVS_WRITEDATA_I[5:0];
        end
        `IRP_RX_TGT1_OFS: begin
          if (AVS_BYTEENABLE_I[0]) rx_target_rate_q[1] <= AVS_WRITEDATA_I[5:0];
        end
        `IRP_RX_TGT2_OFS: begin
          if (AVS_BYTEENABLE_I[0]) rx_target_rate_q[2] <= AVS_WRITEDATA_I[5:0];
        end
        `IRP_TX_TGT0_OFS: begin
          if (AVS_BYTEENABLE_I[0]) tx_target_rate_q[0] <= AVS_WRITEDATA_I[5:0];
        end
        `IRP_TX_TGT1_OFS: begin
          if (AVS_BYTEENABLE_I[0]) tx_target_rate_q[1] <= AVS_WRITEDATA_I[5:0];
        end
        `IRP_TX_TGT2_OFS: begin
          if (AVS_BYTEENABLE_I[0]) tx_target_rate_q[2] <= AVS_WRITEDATA_I[5:0];
        end
        default: begin
          rx_en_q <= rx_en_q;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////
  // control register packing
  function [31:0] ctrl_rd;
    input [2:0]            rx_en;
    input [2:0]            tx_en;
    input [`IRP_PRE_W-1:0] pre;
    begin
      ctrl_rd = 32'h00000000;
      ctrl_rd[`IRP_CTRL_RXEN_LSB +: 3]        = rx_en;
      ctrl_rd[`IRP_CTRL_TXEN_LSB +: 3]        = tx_en;
      ctrl_rd[`IRP_CTRL_PRE_LSB +: `IRP_PRE_W] = pre;
    end
  endfunction

  function [`IRP_PRE_W+5:0] control_next;
    input [31:0] v;
    begin
      control_next = {v[`IRP_CTRL_PRE_LSB +: `IRP_PRE_W], v[`IRP_CTRL_TXEN_LSB +: 3], v[`IRP_CTRL_RXEN_LSB +: 3]};
    end
  endfunction

  ////////////////////////////////////////////////////////////
  // read mux, reserved bits zero
  always @* begin
    rd_mux = 32'h00000000;
    case (AVS_ADDRESS_I)
      `IRP_CTRL_OFS:    rd_mux = ctrl_rd(rx_en_q, tx_en_q, tick_prescale_q);
      `IRP_RX_TGT0_OFS: rd_mux = {26'h0000000, rx_target_rate_q[0]};
      `IRP_RX_TGT1_OFS: rd_mux = {26'h0000000, rx_target_rate_q[1]};
      `IRP_RX_TGT2_OFS: rd_mux = {26'h0000000, rx_target_rate_q[2]};
      `IRP_TX_TGT0_OFS: rd_mux = {26'h0000000, tx_target_rate_q[0]};
      `IRP_TX_TGT1_OFS: rd_mux = {26'h0000000, tx_target_rate_q[1]};
      `IRP_TX_TGT2_OFS: rd_mux = {26'h0000000, tx_target_rate_q[2]};
      `IRP_PACE0_OFS:   rd_mux = {16'h0000, tx_pace[0], rx_pace[0]};
      `IRP_PACE1_OFS:   rd_mux = {16'h0000, tx_pace[1], rx_pace[1]};
      `IRP_PACE2_OFS:   rd_mux = {16'h0000, tx_pace[2], rx_pace[2]};
      `IRP_WIN_OFS:     rd_mux = {{(32-`IRP_IDX_W){1'b0}}, idx_q};
      default:          rd_mux = 32'h00000000;
    endcase
  end

  always @(posedge CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      AVS_READDATA_O <= 32'h00000000;
    end else if (rd_take) begin
      AVS_READDATA_O <= rd_mux;
    end
  end

  ////////////////////////////////////////////////////////////
  // tick divider and shared window index
  assign pre_eff = (tick_prescale_q == 12'h000) ? 12'h001 : tick_prescale_q;
  assign win_prod = {{(32-`IRP_PRE_W){1'b0}}, pre_eff} * `IRP_TICKS_PER_PRE;
  assign win_len  = win_prod[`IRP_IDX_W-1:0];
  assign win_end = tick_q && (idx_q >= win_len - 20'h00001);

  always @(posedge CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      div_q  <= 16'h0000;
      tick_q <= 1'b0;
    end else if (div_q >= TICK_DIV - 1) begin
      div_q  <= 16'h0000;
      tick_q <= 1'b1;
    end else begin
      div_q  <= div_q + 16'h0001;
      tick_q <= 1'b0;
    end
  end

  always @(posedge CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      idx_q <= 20'h00000;
    end else if (win_end) begin
      idx_q <= 20'h00000;
    end else if (tick_q) begin
      idx_q <= idx_q + 20'h00001;
    end
  end

  ////////////////////////////////////////////////////////////
  // six independent pacers
  genvar g;
  generate
    for (g = 0; g < 3; g = g + 1) begin : core
      irp_pacer u_rx (
        .clk_i      (CLK_I),
        .rst_i      (SYS_RST_I),
        .win_end_i  (win_end),
        .idx_i      (idx_q),
        .prescale_i (pre_eff),
        .target_i   (rx_target_rate_q[g]),
        .enable_i   (rx_en_q[g]),
        .event_i    (RX_EVENT_I[g]),
        .pulse_o    (CORE_RX_PACED_IRQ_O[g]),
        .pace_o     (rx_pace[g])
      );
      irp_pacer u_tx (
        .clk_i      (CLK_I),
        .rst_i      (SYS_RST_I),
        .win_end_i  (win_end),
        .idx_i      (idx_q),
        .prescale_i (pre_eff),
        .target_i   (tx_target_rate_q[g]),
        .enable_i   (tx_en_q[g]),
        .event_i    (TX_EVENT_I[g]),
        .pulse_o    (CORE_TX_PACED_IRQ_O[g]),
        .pace_o     (tx_pace[g])
      );
    end
  endgenerate

endmodule
